// ==== verilog/dmac_pkg.sv ====
// dmac_pkg: constants, bus offsets and op codes for the mac datapath
// assumes a 32-bit classic wishbone slave and one 125 MHz clock
package dmac_pkg;
	// register word offsets (byte addresses)
	localparam logic [7:0] DMAC_OFS_CONFIG  = 8'h00;
	localparam logic [7:0] DMAC_OFS_TRAPCTL = 8'h04;
	localparam logic [7:0] DMAC_OFS_FLAGS   = 8'h08;
	localparam logic [7:0] DMAC_OFS_ACCA_LO = 8'h0C;
	localparam logic [7:0] DMAC_OFS_ACCA_HI = 8'h10;
	localparam logic [7:0] DMAC_OFS_ACCB_LO = 8'h14;
	localparam logic [7:0] DMAC_OFS_ACCB_HI = 8'h18;
	localparam logic [7:0] DMAC_OFS_WBPTR   = 8'h1C;
	localparam logic [7:0] DMAC_OFS_PRODUCT = 8'h20;
	localparam logic [7:0] DMAC_OFS_WBDATA  = 8'h24;
	// config register field positions
	localparam int DMAC_CFG_FRAC_INT = 0;
	localparam int DMAC_CFG_ROUND    = 1;
	localparam int DMAC_CFG_WIDTH    = 4;
	localparam int DMAC_CFG_CLIP_B   = 6;
	localparam int DMAC_CFG_CLIP_A   = 7;
	localparam int DMAC_CFG_SIGN     = 12;
	localparam logic [15:0] DMAC_CFG_RESET = 16'h0000;
	// trap control field positions
	localparam int DMAC_TRP_FATAL  = 0;
	localparam int DMAC_TRP_GUARDB = 1;
	localparam int DMAC_TRP_GUARDA = 2;
	// flags register field positions (write 1 to clear clip bits)
	localparam int DMAC_FLG_GA   = 0;
	localparam int DMAC_FLG_GB   = 1;
	localparam int DMAC_FLG_CA   = 2;
	localparam int DMAC_FLG_CB   = 3;
	localparam int DMAC_FLG_GANY = 4;
	localparam int DMAC_FLG_CANY = 5;
	localparam int DMAC_FLG_TRAP = 6;
	// saturation values
	localparam logic [39:0] DMAC_MAX40 = 40'h7FFFFFFFFF;
	localparam logic [39:0] DMAC_MIN40 = 40'h8000000000;
	localparam logic [39:0] DMAC_MAX32 = 40'h007FFFFFFF;
	localparam logic [39:0] DMAC_MIN32 = 40'h0080000000;
	localparam logic [15:0] DMAC_HALF  = 16'h8000;
	localparam logic [15:0] DMAC_PTR_STEP = 16'h0002;
	// operations issued by the decoder
	typedef enum logic [3:0] {
		DMAC_OP_NONE    = 4'h0,
		DMAC_OP_MAC     = 4'h1,
		DMAC_OP_MSC     = 4'h2,
		DMAC_OP_MPY     = 4'h3,
		DMAC_OP_MPYN    = 4'h4,
		DMAC_OP_ED      = 4'h5,
		DMAC_OP_DISTANCE_SQUARE_ACC_OP    = 4'h6,
		DMAC_OP_ADD     = 4'h7,
		DMAC_OP_LAC     = 4'h8,
		DMAC_OP_SAC     = 4'h9,
		DMAC_OP_SACR    = 4'hA,
		DMAC_OP_IMUL    = 4'hB,
		DMAC_OP_CLR     = 4'hC
	} dmac_op_t;
	// write-back destinations
	typedef enum logic [1:0] {
		DMAC_WB_NONE = 2'h0,
		DMAC_WB_REG  = 2'h1,
		DMAC_WB_IND  = 2'h2
	} dmac_wb_t;
endpackage

// ==== verilog/dmac_datapath.sv ====
// dmac_datapath: multiply-accumulate datapath with two 40-bit accumulators
// assumes the decoder pulses op_valid_i for one cycle per operation and a
// classic wishbone master for configuration and status
//
// Local design decisions: the Wishbone register port and the register offsets.
`timescale 1ns/100ps

// What this block does
// - widen operands to 17 bits by sign
// - 33-bit product sign-extended to 40 bits
// - fractional gives 1.31, integer plain product
// - integer multiply: byte 16-bit, word 32-bit
// - adder reads and writes selected accumulator
// - add and load take pre-shifted operand
// - add true carry, subtract complement borrow
// - guard flag set when bits 39..32 differ
// - combined guard and clip bits are ORs
// - guard flag with enable raises trap
// - clip flag sticky, software clears only
// - clip disabled: flag bit 39, fatal trap
// - 9.31 clip loads 40-bit extremes
// - 1.31 clip loads 1.31 extremes
// - 1.31 clipping never sets guard flags
// - clip disabled keeps raw result
// - clip logic uses result, flags, enables, width
// - mac class writes non-target high word
// - write-back to pointer or indirect plus two
// - no rounding truncates low word
// - conventional: increment when low word >= 8000
// - convergent: tie uses accumulator bit 16
// - store trunc/round; mac write-back always rounded
// - width select one: 9.31, zero: 1.31
// - round select one conventional, zero convergent
// - sign select one unsigned, zero signed
// - format select one integer, zero fractional
module dmac_datapath (
	// clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   rst_n_i,
	// wishbone slave
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [7:0]             wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic      [31:0]            wb_dat_o,
	output logic                        wb_ack_o,
	// decoder operation
	input  wire logic                   op_valid_i,
	input  wire dmac_pkg::dmac_op_t     op_code_i,
	input  wire logic                   op_target_b_i,
	input  wire logic                   op_byte_i,
	input  wire logic                   op_zero_acc_i,
	input  wire logic                   op_round_i,
	input  wire dmac_pkg::dmac_wb_t     op_wb_mode_i,
	input  wire logic [15:0]            op_x_i,
	input  wire logic [15:0]            op_y_i,
	input  wire logic [39:0]            op_shifted_i,
	// results to register array and data space
	output logic [31:0]                 int_product_o,
	output logic                        int_product_vld_o,
	output logic [15:0]                 store_data_o,
	output logic [15:0]                 store_addr_o,
	output logic                        store_vld_o,
	output logic [15:0]                 writeback_pointer_reg_o,
	output logic                        arith_trap_o
);
	import dmac_pkg::*;

	logic [15:0] core_config_reg;
	logic [2:0]  trap_control_reg;
	logic [39:0] acc_a;
	logic [39:0] acc_b;
	logic        guard_overflow_a;
	logic        guard_overflow_b;
	logic        clip_flag_a;
	logic        clip_flag_b;
	logic [15:0] writeback_pointer_reg;

	// round a 40-bit accumulator to a 1.15 word
	function automatic logic [15:0] round_word(input logic [39:0] acc, input logic conv);
		logic [15:0] hi;
		logic [15:0] lo;
		logic        inc;
		hi  = acc[31:16];
		lo  = acc[15:0];
		inc = lo[15];
		if (conv && lo == DMAC_HALF)
			inc = acc[16];
		round_word = hi + {15'h0000, inc};
	endfunction

	// widen an operand to 17 bits
	function automatic logic [16:0] widen(input logic [15:0] v, input logic uns);
		widen = {uns ? 1'b0 : v[15], v};
	endfunction

	// configuration decode
	wire logic acc_a_clip_en     = core_config_reg[DMAC_CFG_CLIP_A];
	wire logic acc_b_clip_en     = core_config_reg[DMAC_CFG_CLIP_B];
	wire logic clip_width_sel    = core_config_reg[DMAC_CFG_WIDTH];
	wire logic round_style_sel   = core_config_reg[DMAC_CFG_ROUND];
	wire logic product_sign_sel  = core_config_reg[DMAC_CFG_SIGN];
	wire logic product_int_sel   = core_config_reg[DMAC_CFG_FRAC_INT];
	wire logic fatal_overflow_trap_en = trap_control_reg[DMAC_TRP_FATAL];
	wire logic guard_trap_en_a   = trap_control_reg[DMAC_TRP_GUARDA];
	wire logic guard_trap_en_b   = trap_control_reg[DMAC_TRP_GUARDB];

	// multiplier and scaler
	wire logic        is_ed   = (op_code_i == DMAC_OP_ED) || (op_code_i == DMAC_OP_DISTANCE_SQUARE_ACC_OP);
	wire logic [15:0] diff    = op_x_i - op_y_i;
	wire logic [15:0] mul_a   = is_ed ? diff : op_x_i;
	wire logic [15:0] mul_b   = is_ed ? diff : op_y_i;
	wire logic [16:0] wide_a  = widen(mul_a, product_sign_sel);
	wire logic [16:0] wide_b  = widen(mul_b, product_sign_sel);
	wire logic [33:0] raw_prd = 34'($signed(wide_a) * $signed(wide_b));
	wire logic [32:0] prod33  = product_int_sel ? raw_prd[32:0]
	                                            : {raw_prd[31:0], 1'b0};
	wire logic [39:0] prod40  = {{7{prod33[32]}}, prod33};

	// integer multiply path for the register array
	wire logic [16:0] ia      = widen(op_byte_i ? {8'h00, op_x_i[7:0]} : op_x_i, product_sign_sel);
	wire logic [16:0] ib      = widen(op_byte_i ? {8'h00, op_y_i[7:0]} : op_y_i, product_sign_sel);
	wire logic [33:0] iprd    = 34'($signed(ia) * $signed(ib));
	wire logic [31:0] imul    = op_byte_i ? {16'h0000, iprd[15:0]} : iprd[31:0];

	// adder operand selection
	wire logic [39:0] src_acc = op_target_b_i ? acc_b : acc_a;
	wire logic        use_shift = (op_code_i == DMAC_OP_ADD) || (op_code_i == DMAC_OP_LAC);
	wire logic        subtract  = (op_code_i == DMAC_OP_MSC) || (op_code_i == DMAC_OP_MPYN);
	wire logic        no_acc    = op_zero_acc_i || (op_code_i == DMAC_OP_MPY) ||
	                              (op_code_i == DMAC_OP_MPYN) || (op_code_i == DMAC_OP_ED) ||
	                              (op_code_i == DMAC_OP_LAC) || (op_code_i == DMAC_OP_CLR);
	wire logic        is_clr    = (op_code_i == DMAC_OP_CLR);
	wire logic [39:0] operand   = is_clr ? 40'h0000000000
	                            : (use_shift ? op_shifted_i : prod40);
	wire logic [39:0] add_a     = no_acc ? 40'h0000000000 : src_acc;
	wire logic [39:0] add_b     = subtract ? ~operand : operand;
	wire logic        carry_in  = subtract;
	wire logic [40:0] sum41     = {1'b0, add_a} + {1'b0, add_b} + {40'h0000000000, carry_in};
	wire logic [39:0] sum       = sum41[39:0];
	wire logic        uses_adder = op_valid_i && (op_code_i != DMAC_OP_NONE) &&
	                               (op_code_i != DMAC_OP_SAC) && (op_code_i != DMAC_OP_SACR) &&
	                               (op_code_i != DMAC_OP_IMUL);

	// overflow detection: bit 39 by operand and result signs, bit 31 by upper nine bits
	wire logic ov39  = (add_a[39] == add_b[39]) && (sum[39] != add_a[39]);
	wire logic ov31  = ~((&sum[39:31]) | ~(|sum[39:31]));
	wire logic guard = ~((&sum[39:32]) | ~(|sum[39:32]));
	wire logic clip_en  = op_target_b_i ? acc_b_clip_en : acc_a_clip_en;
	wire logic negative = ov39 ? add_a[39] : sum[39];

	// clip decision and value
	wire logic sat31   = clip_en && !clip_width_sel && (ov31 || ov39);
	wire logic sat39   = clip_en && clip_width_sel && ov39;
	wire logic clip_ev = clip_en ? (sat31 || sat39) : ov39;
	wire logic [39:0] result = sat39 ? (negative ? DMAC_MIN40 : DMAC_MAX40)
	                         : sat31 ? (negative ? DMAC_MIN32 : DMAC_MAX32)
	                         : sum;
	wire logic guard_ev = guard && !(clip_en && !clip_width_sel);

	// write-back of the non-target accumulator
	wire logic        is_mac_cls = (op_code_i == DMAC_OP_MAC) || (op_code_i == DMAC_OP_MSC) ||
	                               (op_code_i == DMAC_OP_CLR);
	wire logic        do_wb      = op_valid_i && is_mac_cls && (op_wb_mode_i != DMAC_WB_NONE);
	wire logic [39:0] other_acc  = op_target_b_i ? acc_a : acc_b;
	wire logic [15:0] wb_word    = round_word(other_acc, !round_style_sel);
	wire logic        is_store   = op_valid_i &&
	                               ((op_code_i == DMAC_OP_SAC) || (op_code_i == DMAC_OP_SACR));
	wire logic        st_round   = (op_code_i == DMAC_OP_SACR) || op_round_i;
	wire logic [15:0] st_word    = st_round ? round_word(src_acc, !round_style_sel)
	                                        : src_acc[31:16];

	// wishbone decode
	wire logic        bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire logic        bus_wr   = bus_req && wb_we_i && wb_sel_i[0];
	wire logic        wr_cfg   = bus_wr && (wb_adr_i == DMAC_OFS_CONFIG);
	wire logic        wr_trap  = bus_wr && (wb_adr_i == DMAC_OFS_TRAPCTL);
	wire logic        wr_flag  = bus_wr && (wb_adr_i == DMAC_OFS_FLAGS);
	wire logic        wr_ptr   = bus_wr && (wb_adr_i == DMAC_OFS_WBPTR);
	wire logic        clr_ca   = wr_flag && wb_dat_i[DMAC_FLG_CA];
	wire logic        clr_cb   = wr_flag && wb_dat_i[DMAC_FLG_CB];
	wire logic        any_guard_overflow = guard_overflow_a | guard_overflow_b;
	wire logic        any_clip_flag      = clip_flag_a | clip_flag_b;
	logic [31:0]      rd_mux;
	always_comb begin
		rd_mux = 32'h00000000;
		unique case (wb_adr_i)
			DMAC_OFS_CONFIG:  rd_mux = {16'h0000, core_config_reg};
			DMAC_OFS_TRAPCTL: rd_mux = {29'h00000000, trap_control_reg};
			DMAC_OFS_FLAGS:   rd_mux = {25'h0000000, arith_trap_o, any_clip_flag,
			                            any_guard_overflow, clip_flag_b, clip_flag_a,
			                            guard_overflow_b, guard_overflow_a};
			DMAC_OFS_ACCA_LO: rd_mux = acc_a[31:0];
			DMAC_OFS_ACCA_HI: rd_mux = {24'h000000, acc_a[39:32]};
			DMAC_OFS_ACCB_LO: rd_mux = acc_b[31:0];
			DMAC_OFS_ACCB_HI: rd_mux = {24'h000000, acc_b[39:32]};
			DMAC_OFS_WBPTR:   rd_mux = {16'h0000, writeback_pointer_reg};
			DMAC_OFS_PRODUCT: rd_mux = int_product_o;
			DMAC_OFS_WBDATA:  rd_mux = {16'h0000, store_data_o};
			default:          rd_mux = 32'h00000000;
		endcase
	end

	// next accumulator and flag values
	wire logic upd_a = uses_adder && !op_target_b_i;
	wire logic upd_b = uses_adder && op_target_b_i;
	wire logic next_ga = upd_a ? guard_ev : guard_overflow_a;
	wire logic next_gb = upd_b ? guard_ev : guard_overflow_b;
	wire logic set_ca  = upd_a && clip_ev;
	wire logic set_cb  = upd_b && clip_ev;
	wire logic next_trap = (guard_trap_en_a && next_ga && !guard_overflow_a) ||
	                       (guard_trap_en_b && next_gb && !guard_overflow_b) ||
	                       (fatal_overflow_trap_en && (set_ca || set_cb) && !clip_en);

	// bus slave registers
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wb_ack_o         <= 1'b0;
			wb_dat_o         <= 32'h00000000;
			core_config_reg  <= DMAC_CFG_RESET;
			trap_control_reg <= 3'h0;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= bus_req ? rd_mux : 32'h00000000;
			if (wr_cfg)
				core_config_reg <= wb_dat_i[15:0];
			if (wr_trap)
				trap_control_reg <= wb_dat_i[2:0];
		end
	end

	// accumulators and status flags; a set wins over a software clear
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			acc_a            <= 40'h0000000000;
			acc_b            <= 40'h0000000000;
			guard_overflow_a <= 1'b0;
			guard_overflow_b <= 1'b0;
			clip_flag_a      <= 1'b0;
			clip_flag_b      <= 1'b0;
			arith_trap_o     <= 1'b0;
		end else begin
			if (upd_a)
				acc_a <= result;
			if (upd_b)
				acc_b <= result;
			guard_overflow_a <= next_ga;
			guard_overflow_b <= next_gb;
			clip_flag_a      <= set_ca | (clip_flag_a & ~clr_ca);
			clip_flag_b      <= set_cb | (clip_flag_b & ~clr_cb);
			arith_trap_o     <= next_trap;
		end
	end

	// results, store and write-back
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			int_product_o         <= 32'h00000000;
			int_product_vld_o     <= 1'b0;
			store_data_o          <= 16'h0000;
			store_addr_o          <= 16'h0000;
			store_vld_o           <= 1'b0;
			writeback_pointer_reg <= 16'h0000;
		end else begin
			int_product_vld_o <= op_valid_i && (op_code_i == DMAC_OP_IMUL);
			if (op_valid_i && (op_code_i == DMAC_OP_IMUL))
				int_product_o <= imul;
			store_vld_o <= is_store || (do_wb && op_wb_mode_i == DMAC_WB_IND);
			if (is_store) begin
				store_data_o <= st_word;
				store_addr_o <= writeback_pointer_reg;
			end else if (do_wb) begin
				store_data_o <= wb_word;
				store_addr_o <= writeback_pointer_reg;
			end
			if (do_wb && op_wb_mode_i == DMAC_WB_REG)
				writeback_pointer_reg <= wb_word;
			else if (do_wb && op_wb_mode_i == DMAC_WB_IND)
				writeback_pointer_reg <= writeback_pointer_reg + DMAC_PTR_STEP;
			else if (wr_ptr)
				writeback_pointer_reg <= wb_dat_i[15:0];
		end
	end

	// pointer mirror for the register array
	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			writeback_pointer_reg_o <= 16'h0000;
		else
			writeback_pointer_reg_o <= writeback_pointer_reg;
	end
endmodule

// ==== sim/dmac_checker_properties.sv ====
// dmac_checker: concurrent checks on the mac datapath ports
// assumes it is bound into dmac_datapath; one clock domain
`timescale 1ns/100ps
module dmac_checker (
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_n_i,
	// bus and operation inputs
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               op_valid_i,
	input  wire dmac_pkg::dmac_op_t op_code_i,
	input  wire logic               op_byte_i,
	input  wire dmac_pkg::dmac_wb_t op_wb_mode_i,
	// outputs under watch
	input  wire logic               wb_ack_o,
	input  wire logic [31:0]        int_product_o,
	input  wire logic               int_product_vld_o,
	input  wire logic               store_vld_o,
	input  wire logic [15:0]        store_addr_o,
	input  wire logic [15:0]        writeback_pointer_reg_o,
	input  wire logic               arith_trap_o
);
	import dmac_pkg::*;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// bus answer comes one cycle later and lasts one cycle
	AST_ACK_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus answer longer than one cycle");
	// integer product strobe and width
	AST_IMUL_RESULT: assert property (op_valid_i && op_code_i == DMAC_OP_IMUL |=> int_product_vld_o)
		else $error("integer product strobe missing");
	AST_IMUL_CAUSE: assert property (int_product_vld_o |-> $past(op_valid_i) &&
		$past(op_code_i) == DMAC_OP_IMUL)
		else $error("integer product strobe without request");
	AST_IMUL_BYTE: assert property (op_valid_i && op_code_i == DMAC_OP_IMUL && op_byte_i
		|=> int_product_o[31:16] == 16'h0000)
		else $error("byte product wider than a word");
	// data space writes only from store and indirect write-back
	AST_STORE_CAUSE: assert property (store_vld_o |-> $past(op_valid_i) &&
		($past(op_code_i) inside {DMAC_OP_SAC, DMAC_OP_SACR} || $past(op_wb_mode_i) ==
		DMAC_WB_IND && $past(op_code_i) inside {DMAC_OP_MAC, DMAC_OP_MSC, DMAC_OP_CLR}))
		else $error("data write without cause");
	AST_NO_WRITEBACK: assert property (op_valid_i && op_code_i inside {DMAC_OP_MPY,
		DMAC_OP_MPYN, DMAC_OP_ED, DMAC_OP_DISTANCE_SQUARE_ACC_OP} |=> !store_vld_o)
		else $error("write-back from excluded operation");
	// pointer moves by two after an indirect write-back
	AST_PTR_STEP: assert property (op_valid_i && op_wb_mode_i == DMAC_WB_IND &&
		op_code_i inside {DMAC_OP_MAC, DMAC_OP_MSC}
		|=> ##1 writeback_pointer_reg_o == $past(store_addr_o) + DMAC_PTR_STEP)
		else $error("pointer not advanced by two");
	AST_DIRECT_SILENT: assert property (op_valid_i && op_wb_mode_i == DMAC_WB_REG &&
		op_code_i inside {DMAC_OP_MAC, DMAC_OP_MSC} |=> !store_vld_o)
		else $error("direct write-back touched data space");
	AST_TRAP_CAUSE: assert property (arith_trap_o |-> $past(op_valid_i))
		else $error("trap request without an operation");
endmodule
bind dmac_datapath dmac_checker chk_u (.clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .op_valid_i,
	.op_code_i, .op_byte_i, .op_wb_mode_i, .wb_ack_o, .int_product_o, .int_product_vld_o,
	.store_vld_o, .store_addr_o, .writeback_pointer_reg_o, .arith_trap_o);

// ==== sim/dmac_decoder_model.sv ====
// dmac_decoder_model: behavioural decoder issuing one operation per call
// assumes the bench calls issue and waits for it to return
`timescale 1ns/100ps
module dmac_decoder_model (
	// clock
	input  wire logic               clk_i,
	// operation towards the datapath
	output logic                    op_valid_o,
	output dmac_pkg::dmac_op_t      op_code_o,
	output logic                    op_target_b_o,
	output logic                    op_byte_o,
	output logic                    op_zero_acc_o,
	output logic                    op_round_o,
	output dmac_pkg::dmac_wb_t      op_wb_mode_o,
	output logic [15:0]             op_x_o,
	output logic [15:0]             op_y_o,
	output logic [39:0]             op_shifted_o
);
	import dmac_pkg::*;
	// quiet lines at time zero
	initial begin
		op_valid_o = 1'b0;
		op_code_o = DMAC_OP_NONE;
		op_wb_mode_o = DMAC_WB_NONE;
		{op_target_b_o, op_byte_o, op_zero_acc_o, op_round_o} = 4'h0;
		{op_x_o, op_y_o, op_shifted_o} = 72'h0;
	end
	// one pulse; operands toggle once released so stale values never match
	task automatic issue(input dmac_op_t c, input logic b, by, z, r, input dmac_wb_t w,
		input logic [15:0] x, y, input logic [39:0] s);
		@(posedge clk_i);
		op_valid_o <= 1'b1;
		op_code_o <= c;
		op_wb_mode_o <= w;
		{op_target_b_o, op_byte_o, op_zero_acc_o, op_round_o} <= {b, by, z, r};
		{op_x_o, op_y_o, op_shifted_o} <= {x, y, s};
		@(posedge clk_i);
		op_valid_o <= 1'b0;
		{op_x_o, op_y_o, op_shifted_o} <= ~{op_x_o, op_y_o, op_shifted_o};
		#1;
	endtask
endmodule

// ==== sim/dmac_datapath_bench.sv ====
// dmac_datapath_bench: self-checking bench for the mac datapath
// assumes the decoder model and the bound checker
`timescale 1ns/100ps
module dmac_datapath_bench;
	import dmac_pkg::*;
	typedef struct packed {
		logic [15:0] cfg;
		logic [2:0]  trp;
		logic        b;
		logic [39:0] ld;
		logic [39:0] ad;
		logic [39:0] acc;
		logic [6:0]  flg;
		logic [6:0]  msk;
		logic        trap;
	} dmac_row_t;
	logic        clk_i = 1'b0, rst_n_i = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
	logic        wb_ack, op_valid, op_tb, op_byte, op_zero, op_round, prod_vld, st_vld, trap;
	logic [7:0]  wb_adr = 8'h00;
	logic [31:0] wb_wdat = 32'h0, wb_rdat, prod;
	logic [15:0] op_x, op_y, st_data, st_addr, wb_ptr;
	logic [39:0] op_sh;
	dmac_op_t    op_code;
	dmac_wb_t    op_wb;
	int          fail_count = 0, compares = 0;
	integer      seed = 32'h8C06E015;
	// load, add, expected accumulator, flags, flag mask, trap
	dmac_row_t   rows [6] = '{
		'{16'h0000, 3'h1, 1'b0, 40'h7FFFFFFFFF, 40'h1, 40'h8000000000, 7'h35, 7'h3F, 1'b1},
		'{16'h0000, 3'h4, 1'b0, 40'h0, 40'h0100000000, 40'h0100000000, 7'h11, 7'h3F, 1'b1},
		'{16'h0090, 3'h1, 1'b0, 40'h7FFFFFFFFF, 40'h1, 40'h7FFFFFFFFF, 7'h24, 7'h2C, 1'b0},
		'{16'h0050, 3'h1, 1'b1, 40'h8000000000, 40'hFFFFFFFFFF, 40'h8000000000, 7'h28, 7'h2C, 1'b0},
		'{16'h0080, 3'h1, 1'b0, 40'h007FFFFFFF, 40'h1, 40'h007FFFFFFF, 7'h24, 7'h2D, 1'b0},
		'{16'h0040, 3'h1, 1'b1, 40'hFF80000000, 40'hFFFFFFFFFF, 40'h0080000000, 7'h28, 7'h3F, 1'b0}};
	always #4 clk_i = ~clk_i;
	dmac_decoder_model dec_u (.clk_i(clk_i), .op_valid_o(op_valid), .op_code_o(op_code),
		.op_target_b_o(op_tb), .op_byte_o(op_byte), .op_zero_acc_o(op_zero),
		.op_round_o(op_round), .op_wb_mode_o(op_wb), .op_x_o(op_x), .op_y_o(op_y),
		.op_shifted_o(op_sh));
	dmac_datapath dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat),
		.wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .op_valid_i(op_valid), .op_code_i(op_code),
		.op_target_b_i(op_tb), .op_byte_i(op_byte), .op_zero_acc_i(op_zero),
		.op_round_i(op_round), .op_wb_mode_i(op_wb), .op_x_i(op_x), .op_y_i(op_y),
		.op_shifted_i(op_sh), .int_product_o(prod), .int_product_vld_o(prod_vld),
		.store_data_o(st_data), .store_addr_o(st_addr), .store_vld_o(st_vld),
		.writeback_pointer_reg_o(wb_ptr), .arith_trap_o(trap));
	// verdict and end of run
	task automatic results();
		if (fail_count == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one classic bus cycle, bounded wait for the answer
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n = 0;
		@(posedge clk_i);
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat} <= {2'b11, we, a, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack !== 1'b1 && n < 16);
		q = wb_rdat;
		{wb_cyc, wb_stb} <= 2'b00;
		if (wb_ack !== 1'b1) begin
			fail_count++;
			results();
		end
	endtask
	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(what, q, exp);
	endtask
	task automatic acc_chk(input string what, input logic b, input logic [39:0] exp);
		logic [31:0] lo, hi;
		wb(1'b0, b ? DMAC_OFS_ACCB_LO : DMAC_OFS_ACCA_LO, 32'h0, lo);
		wb(1'b0, b ? DMAC_OFS_ACCB_HI : DMAC_OFS_ACCA_HI, 32'h0, hi);
		chk(what, {hi[7:0], lo}, exp);
	endtask
	task automatic op(input dmac_op_t c, input logic b, input logic [39:0] s);
		dec_u.issue(c, b, 1'b0, 1'b0, 1'b0, DMAC_WB_NONE, 16'h0, 16'h0, s);
	endtask
	// expected engine product for the chosen sign and format
	function automatic logic [39:0] prod40(input logic [15:0] x, y, cfg);
		logic [39:0] p;
		p = cfg[DMAC_CFG_SIGN] ? {24'h0, x} * {24'h0, y} : {{24{x[15]}}, x} * {{24{y[15]}}, y};
		return cfg[DMAC_CFG_FRAC_INT] ? p : p << 1;
	endfunction
	function automatic logic [15:0] rnd16(input logic [39:0] a, input logic conv);
		return a[31:16] + 16'((a[15:0] > DMAC_HALF) || (a[15:0] == DMAC_HALF && (conv || a[16])));
	endfunction
	// main sequence
	initial begin
		logic [31:0] q;
		logic [15:0] cfg, x, y, hi, lo;
		logic [39:0] a, e;
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rdchk("config reset", DMAC_OFS_CONFIG, {16'h0, DMAC_CFG_RESET});
		rdchk("flags reset", DMAC_OFS_FLAGS, 32'h0);
		wb(1'b1, 8'h3C, 32'hFFFF, q);
		rdchk("unmapped", 8'h3C, 32'h0);
		for (int i = 0; i < 24; i++) begin
			cfg = (i % 3 == 2) ? 16'h1001 : 16'(i % 3);
			x = 16'($random(seed));
			y = 16'($random(seed));
			wb(1'b1, DMAC_OFS_CONFIG, {16'h0, cfg}, q);
			dec_u.issue(DMAC_OP_MPY, i[0], 1'b0, 1'b0, 1'b0, DMAC_WB_IND, x, y, 40'h0);
			acc_chk("product", i[0], prod40(x, y, cfg));
			a = {{8{x[15]}}, x, y};
			op(DMAC_OP_LAC, i[1], a);
			e = i[2] ? 40'h0 : a;
			e = i[0] ? e - prod40(y, x, cfg) : e + prod40(y, x, cfg);
			dec_u.issue(i[0] ? DMAC_OP_MSC : DMAC_OP_MAC, i[1], 1'b0, i[2], 1'b0, DMAC_WB_NONE,
				y, x, 40'h0);
			acc_chk("acc sum", i[1], e);
			dec_u.issue(i[0] ? DMAC_OP_DISTANCE_SQUARE_ACC_OP : DMAC_OP_ED, i[1], 1'b0, 1'b0, 1'b0, DMAC_WB_NONE,
				x, y, 40'h0);
			e = (i[0] ? e : 40'h0) + prod40(16'(x - y), 16'(x - y), cfg);
			acc_chk("square", i[1], e);
			dec_u.issue(i[0] ? DMAC_OP_CLR : DMAC_OP_MPYN, i[1], 1'b0, 1'b0, 1'b0, DMAC_WB_NONE,
				x, y, 40'h0);
			acc_chk("negate", i[1], i[0] ? 40'h0 : 40'h0 - prod40(x, y, cfg));
			x[15] = 1'b0;
			y[15] = 1'b0;
			dec_u.issue(DMAC_OP_IMUL, 1'b0, i[0], 1'b0, 1'b0, DMAC_WB_NONE, x, y, 40'h0);
			chk("int valid", prod_vld, 1'b1);
			e = i[0] ? {24'h0, x[7:0]} * {24'h0, y[7:0]} : {16'h0, x} * {16'h0, y};
			chk("int product", prod, e);
			rdchk("product reg", DMAC_OFS_PRODUCT, e[31:0]);
		end
		op(DMAC_OP_LAC, 1'b1, 40'h0);
		foreach (rows[k]) begin
			wb(1'b1, DMAC_OFS_CONFIG, {16'h0, rows[k].cfg}, q);
			wb(1'b1, DMAC_OFS_TRAPCTL, {29'h0, rows[k].trp}, q);
			wb(1'b1, DMAC_OFS_FLAGS, 32'hC, q);
			op(DMAC_OP_LAC, rows[k].b, rows[k].ld);
			op(DMAC_OP_ADD, rows[k].b, rows[k].ad);
			chk("trap", trap, rows[k].trap);
			acc_chk("clip acc", rows[k].b, rows[k].acc);
			wb(1'b0, DMAC_OFS_FLAGS, 32'h0, q);
			chk("flags", q[6:0] & rows[k].msk, rows[k].flg);
		end
		op(DMAC_OP_LAC, 1'b1, 40'h0);
		wb(1'b0, DMAC_OFS_FLAGS, 32'h0, q);
		chk("sticky clip", q[DMAC_FLG_CB], 1'b1);
		wb(1'b1, DMAC_OFS_FLAGS, 32'h1 << DMAC_FLG_CB, q);
		wb(1'b0, DMAC_OFS_FLAGS, 32'h0, q);
		chk("clip cleared", q[5:0], 6'h00);
		for (int j = 0; j < 16; j++) begin
			lo = (j % 4 == 0) ? 16'h7FFF : (j % 4 == 3) ? 16'hFFFF : 16'h8000;
			hi = 16'($random(seed));
			hi[0] = j[2];
			x = hi & 16'hFFFE;
			a = {8'h00, hi, lo};
			e = {24'h0, rnd16(a, j[3])};
			wb(1'b1, DMAC_OFS_CONFIG, 32'(j[3]) << DMAC_CFG_ROUND, q);
			wb(1'b1, DMAC_OFS_WBPTR, {16'h0, x}, q);
			op(DMAC_OP_LAC, 1'b1, a);
			dec_u.issue(DMAC_OP_MAC, 1'b0, 1'b0, 1'b0, 1'b0, DMAC_WB_IND, 16'h0, 16'h0, 40'h0);
			chk("wb valid", st_vld, 1'b1);
			chk("wb data", st_data, e);
			chk("wb addr", st_addr, x);
			rdchk("wb step", DMAC_OFS_WBPTR, {16'h0, 16'(x + DMAC_PTR_STEP)});
			dec_u.issue(DMAC_OP_MSC, 1'b0, 1'b0, 1'b0, 1'b0, DMAC_WB_REG, 16'h0, 16'h0, 40'h0);
			@(posedge clk_i);
			#1;
			chk("wb reg", wb_ptr, e);
			dec_u.issue(DMAC_OP_SAC, 1'b1, 1'b0, 1'b0, j[0], DMAC_WB_NONE, 16'h0, 16'h0, 40'h0);
			chk("store", st_data, j[0] ? e : {24'h0, hi});
			dec_u.issue(DMAC_OP_SACR, 1'b1, 1'b0, 1'b0, 1'b0, DMAC_WB_NONE, 16'h0, 16'h0, 40'h0);
			chk("store round", st_data, e);
		end
		// second reset in mid-run clears accumulator and pointer
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		acc_chk("acc reset", 1'b1, 40'h0);
		chk("ptr pin reset", wb_ptr, 16'h0);
		rdchk("ptr reset", DMAC_OFS_WBPTR, 32'h0);
		results();
	end
endmodule
